// [rtl/efh_exception_frame_handler.sv]
// Function
// [RULE_01] An unimplemented floating-point instruction vectors through entry 11 and the handler is prefetched before it runs.
// [RULE_02] Return from exception first reads the top supervisor frame to judge its validity and restore kind.
// [RULE_03] Supported frames are four-word, six-word, four-word throwaway, access error and eight-word unimplemented floating-point.
// [RULE_04] A floating-point post-instruction frame is accepted on return but never built.
// [RULE_05] Frame words move as long-word transfers wherever aligned, in any order; the code uses long-words only for long items at long-aligned addresses.
// [RULE_06] The translation test and flush operations raise no exception.
// [RULE_07] Page-scope cache push and invalidate act on a 4-Kbyte block; 8-Kbyte pages are not offered.
// [RULE_08] Control register moves to the user or supervisor root pointer are invalid and have no defined effect.
// [RULE_09] The paging status encoding of a control register move reaches the access control status register.
// [RULE_10] Software should keep the supervisor stack pointer long-word aligned for speed.
// [RULE_11] Handlers should accept any supported frame for any exception.
// [RULE_12] The trap copies the status word, enters supervisor mode, clears both trace bits and pushes the eight-word frame.
// [RULE_13] The trap waits for all earlier integer work and write-backs to finish.
// [RULE_14] An unsupported frame format on return raises a format error instead of a restore.
`timescale 1ns/10ps
`default_nettype none
module efh_exception_frame_handler
  import efh_pkg::*;
(
  input  wire logic        mclk,          // Processor clock, 40 MHz.
  input  wire logic        rst_n,         // Asynchronous reset, active low.
  input  wire logic        fpTrapReq,     // Unimplemented FP instruction seen.
  input  wire logic        priorBusy,     // Earlier integer work pending.
  input  wire logic [15:0] srIn,          // Current status word.
  input  wire logic [31:0] nextPc,        // Address after the FP instruction.
  input  wire logic [31:0] faultPc,       // Address of the FP instruction.
  input  wire logic [31:0] effAddr,       // Calculated effective address.
  input  wire logic [31:0] vbr,           // Vector table base.
  input  wire logic [31:0] sspIn,         // Active supervisor stack pointer.
  input  wire logic        rteReq,        // Return from exception issued.
  input  wire logic        memAck,        // Memory completes the access.
  input  wire logic [31:0] memRdata,      // Memory read data.
  output logic             memReq,        // Memory access request.
  output logic             memWe,         // Memory access is a write.
  output logic             memLong,       // Memory access is a long-word.
  output logic [31:0]      memAddr,       // Memory byte address.
  output logic [31:0]      memWdata,      // Memory write data.
  output logic             busy,          // Sequence in progress.
  output logic             ctxLoad,       // New context valid, one cycle.
  output logic [15:0]      srOut,         // Status word to load.
  output logic [31:0]      pcOut,         // Program counter to load.
  output logic [31:0]      sspOut,        // Stack pointer to load.
  output logic             fmtErr,        // Format error raised, one cycle.
  output logic [7:0]       fmtErrVector,  // Vector of the format error.
  input  wire logic        xlatOpReq,     // Translation test or flush op.
  output logic             xlatOpDone,    // Op retired quietly, one cycle.
  input  wire logic        cacheOpReq,    // Page-scope push or invalidate.
  input  wire logic [31:0] cacheOpAddr,   // Address inside the page.
  output logic             cacheOpGo,     // Block operation start, one cycle.
  output logic [31:0]      cacheBlkBase,  // Base of the 4-Kbyte block.
  input  wire logic        crmReq,        // Control register move.
  input  wire logic        crmWrite,      // Move writes the register.
  input  wire logic [11:0] crmCode,       // Control register encoding.
  input  wire logic [15:0] crmWdata,      // Data written by the move.
  output logic             crmAck,        // Move finished, one cycle.
  output logic [15:0]      crmRdata       // Data read by the move.
);
  efh_state_t  state_q, state_d;
  logic [2:0]  step_q, step_d;
  logic        go_q, go_d, busy_q, busy_d, ctx_q, ctx_d, ferr_q, ferr_d;
  logic [3:0]  fmt_q, fmt_d;
  logic [15:0] cpy_q, cpy_d, sr_q, sr_d;
  logic [31:0] npc_q, npc_d, fpc_q, fpc_d, ea_q, ea_d, vbr_q, vbr_d;
  logic [31:0] ssp_q, ssp_d, pc_q, pc_d;
  logic        xStart, xLong, xWrite, xDone, accState;
  logic [31:0] xAddr, xWdata, xRdata;
  logic        xop_q, cgo_q, cack_q;
  logic [31:0] cbase_q;
  logic [15:0] acsr_q, crd_q;

  // Frame size in bytes for a format code, zero for formats not served.
  function automatic logic [7:0] frameBytes(input logic [3:0] f);
    case (f)
      FMT_SHORT, FMT_THROW:  frameBytes = BYTES_SHORT;               // [RULE_03]
      FMT_SIX, FMT_FP_POST:  frameBytes = BYTES_SIX;                 // [RULE_04]
      FMT_FP_UNIMP:          frameBytes = BYTES_FP_UNIMP;            // [RULE_03]
      FMT_ACC_ERR:           frameBytes = BYTES_ACC_ERR;             // [RULE_03]
      default:               frameBytes = 8'h00;
    endcase
  endfunction : frameBytes

  efh_xfer_seq u_xfer (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .start   (xStart),
    .addr    (xAddr),
    .isLong  (xLong),
    .isWrite (xWrite),
    .wdata   (xWdata),
    .memAck  (memAck),
    .memRdata(memRdata),
    .memReq  (memReq),
    .memWe   (memWe),
    .memLong (memLong),
    .memAddr (memAddr),
    .memWdata(memWdata),
    .done    (xDone),
    .rdata   (xRdata)
  );

  //////////////////////////////////////////////////////////////////////////
  // Exception sequencer. Requests are only taken in idle; a trap wins over a
  // return request in the same cycle, and the return request is not kept.
  always_comb begin
    state_d = state_q; step_d = step_q; fmt_d = fmt_q; cpy_d = cpy_q;
    sr_d = sr_q; npc_d = npc_q; fpc_d = fpc_q; ea_d = ea_q; vbr_d = vbr_q;
    ssp_d = ssp_q; pc_d = pc_q; ctx_d = 1'b0; ferr_d = 1'b0;
    xAddr = ssp_q; xLong = 1'b0; xWrite = 1'b0; xWdata = 32'h0;
    accState = 1'b1;
    case (state_q)
      S_IDLE: begin
        accState = 1'b0;
        if (fpTrapReq) begin
          cpy_d = srIn;
          sr_d  = srIn;
          sr_d[SR_SUPER]      = 1'b1;                                 // [RULE_12]
          sr_d[SR_TRACE_HIGH] = 1'b0;                                 // [RULE_12]
          sr_d[SR_TRACE_LOW]  = 1'b0;                                 // [RULE_12]
          npc_d = nextPc; fpc_d = faultPc; ea_d = effAddr; vbr_d = vbr;
          ssp_d = sspIn;
          state_d = S_TWAIT;
        end else if (rteReq) begin
          ssp_d = sspIn;
          state_d = S_RFMT;
        end
      end
      S_TWAIT: begin
        accState = 1'b0;
        if (!priorBusy) begin                                         // [RULE_13]
          ssp_d = ssp_q - {24'h0, BYTES_FP_UNIMP};
          step_d = 3'h0;
          state_d = S_TPUSH;
        end
      end
      S_TPUSH: begin
        xWrite = 1'b1;
        case (step_q)                                                 // [RULE_12]
          3'h0: xWdata = {16'h0000, cpy_q};
          3'h1: begin xAddr = ssp_q + OFS_PC; xLong = 1'b1; xWdata = npc_q; end
          3'h2: begin xAddr = ssp_q + OFS_FMTVEC; xWdata = {16'h0000, FMTVEC_WORD}; end
          3'h3: begin xAddr = ssp_q + OFS_EA; xLong = 1'b1; xWdata = ea_q; end
          default: begin xAddr = ssp_q + OFS_FPC; xLong = 1'b1; xWdata = fpc_q; end
        endcase
        if (xDone) begin
          step_d = step_q + 3'h1;
          if (step_q == LAST_PUSH_STEP) state_d = S_TVEC;
        end
      end
      S_TVEC: begin
        xAddr = vbr_q + VEC_FLINE_OFS;                                // [RULE_01]
        xLong = 1'b1;
        if (xDone) begin
          pc_d = xRdata;
          state_d = S_TPREF;
        end
      end
      S_TPREF: begin
        xAddr = pc_q;                                                 // [RULE_01]
        xLong = 1'b1;
        if (xDone) begin
          ctx_d = 1'b1;
          state_d = S_IDLE;
        end
      end
      S_RFMT: begin
        xAddr = ssp_q + OFS_FMTVEC;                                   // [RULE_02]
        if (xDone) begin
          fmt_d = xRdata[15:12];
          if (frameBytes(xRdata[15:12]) == 8'h00) begin
            ferr_d = 1'b1;                                            // [RULE_14]
            state_d = S_IDLE;
          end else if (xRdata[15:12] == FMT_THROW) begin
            ssp_d = ssp_q + {24'h0, BYTES_SHORT};
          end else begin
            state_d = S_RSR;
          end
        end
      end
      S_RSR: begin
        if (xDone) begin
          sr_d = xRdata[15:0];
          state_d = S_RPC;
        end
      end
      S_RPC: begin
        xAddr = ssp_q + OFS_PC;
        xLong = 1'b1;                                                 // [RULE_05]
        if (xDone) begin
          pc_d = xRdata;
          ssp_d = ssp_q + {24'h0, frameBytes(fmt_q)};
          ctx_d = 1'b1;
          state_d = S_IDLE;
        end
      end
      default: begin
        accState = 1'b0;
        state_d = S_IDLE;
      end
    endcase
    xStart = accState && !go_q;
    go_d = xDone ? 1'b0 : (go_q || xStart);
    busy_d = (state_d != S_IDLE);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE; step_q <= 3'h0; go_q <= 1'b0; busy_q <= 1'b0;
      ctx_q <= 1'b0; ferr_q <= 1'b0; fmt_q <= 4'h0; cpy_q <= 16'h0;
      sr_q <= 16'h0; npc_q <= 32'h0; fpc_q <= 32'h0; ea_q <= 32'h0;
      vbr_q <= 32'h0; ssp_q <= 32'h0; pc_q <= 32'h0;
    end else begin
      state_q <= state_d; step_q <= step_d; go_q <= go_d; busy_q <= busy_d;
      ctx_q <= ctx_d; ferr_q <= ferr_d; fmt_q <= fmt_d; cpy_q <= cpy_d;
      sr_q <= sr_d; npc_q <= npc_d; fpc_q <= fpc_d; ea_q <= ea_d;
      vbr_q <= vbr_d; ssp_q <= ssp_d; pc_q <= pc_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Side operations. The translation ops retire with no bus cycle at all,
  // which is one legal choice among the arbitrary effects they may have.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      xop_q <= 1'b0; cgo_q <= 1'b0; cack_q <= 1'b0;
      cbase_q <= 32'h0; acsr_q <= ACSR_RESET; crd_q <= 16'h0;
    end else begin
      xop_q <= xlatOpReq;                                             // [RULE_06]
      cgo_q <= cacheOpReq;
      if (cacheOpReq) cbase_q <= {cacheOpAddr[31:PAGE_BITS], {PAGE_BITS{1'b0}}}; // [RULE_07]
      cack_q <= crmReq;
      if (crmReq && crmWrite && crmCode == CRM_ACSR) acsr_q <= crmWdata; // [RULE_09]
      if (crmReq) crd_q <= (crmCode == CRM_ACSR) ? acsr_q : 16'h0;    // [RULE_08]
    end
  end

  assign busy         = busy_q;
  assign ctxLoad      = ctx_q;
  assign srOut        = sr_q;
  assign pcOut        = pc_q;
  assign sspOut       = ssp_q;
  assign fmtErr       = ferr_q;
  assign fmtErrVector = VEC_FMT_ERR;
  assign xlatOpDone   = xop_q;
  assign cacheOpGo    = cgo_q;
  assign cacheBlkBase = cbase_q;
  assign crmAck       = cack_q;
  assign crmRdata     = crd_q;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_vec_fetch_addr: assert property (state_q == S_TVEC && memReq |->
    memAddr == vbr_q + VEC_FLINE_OFS && !memWe) else $error("bad vector fetch"); // [RULE_01]
  a_rte_reads_fmt: assert property ($rose(state_q == S_RFMT) |-> ##1
    (memReq && memAddr == ssp_q + OFS_FMTVEC)) else $error("no format read"); // [RULE_02]
  a_no_post_frame: assert property (memReq && memWe |->
    memAddr != ssp_q + OFS_FMTVEC || memWdata[15:12] == FMT_FP_UNIMP)
    else $error("wrong frame format written"); // [RULE_04]
  a_long_aligned: assert property (memReq && memLong |-> memAddr[1:0] == 2'b00)
    else $error("misaligned long transfer"); // [RULE_05]
  a_xlat_quiet: assert property (xlatOpReq && state_q == S_IDLE |=> xlatOpDone && !fmtErr)
    else $error("translation op misbehaved"); // [RULE_06]
  a_cache_block: assert property (cacheOpReq |=> cacheOpGo &&
    cacheBlkBase == {$past(cacheOpAddr[31:12]), 12'h000}) else $error("bad block"); // [RULE_07]
  a_root_ignored: assert property (crmReq && crmCode == CRM_USER_ROOT |=>
    $stable(acsr_q) && crmRdata == 16'h0000) else $error("root move acted"); // [RULE_08]
  a_acsr_write: assert property (crmReq && crmWrite && crmCode == CRM_ACSR |=>
    acsr_q == $past(crmWdata)) else $error("status move lost"); // [RULE_09]
  a_trap_sr: assert property ($rose(state_q == S_TWAIT) |->
    sr_q[15:13] == 3'b001) else $error("trap status word wrong"); // [RULE_12]
  a_trap_waits: assert property (state_q == S_TWAIT && priorBusy |=>
    state_q == S_TWAIT && !memReq) else $error("trap did not wait"); // [RULE_13]
  a_fmt_error: assert property (state_q == S_RFMT && xDone &&
    frameBytes(xRdata[15:12]) == 8'h00 |=> fmtErr && !ctxLoad && state_q == S_IDLE)
    else $error("format error missed"); // [RULE_14]

  c_trap_done: cover property (state_q == S_TPREF ##[1:40] ctxLoad);
  c_rte_done: cover property (state_q == S_RPC ##[1:40] ctxLoad);
  c_throwaway: cover property (state_q == S_RFMT && xDone && xRdata[15:12] == FMT_THROW);
  c_fmt_err: cover property (fmtErr);
endmodule : efh_exception_frame_handler
`default_nettype wire

// [rtl/efh_pkg.sv]
package efh_pkg;
  localparam logic [7:0]  VEC_FLINE      = 8'h0b;
  localparam logic [7:0]  VEC_FMT_ERR    = 8'h0e;
  localparam logic [31:0] VEC_FLINE_OFS  = 32'h0000002c;
  localparam logic [3:0]  FMT_SHORT      = 4'h0;
  localparam logic [3:0]  FMT_THROW      = 4'h1;
  localparam logic [3:0]  FMT_SIX        = 4'h2;
  localparam logic [3:0]  FMT_FP_POST    = 4'h3;
  localparam logic [3:0]  FMT_FP_UNIMP   = 4'h4;
  localparam logic [3:0]  FMT_ACC_ERR    = 4'h7;
  localparam logic [7:0]  BYTES_SHORT    = 8'h08;
  localparam logic [7:0]  BYTES_SIX      = 8'h0c;
  localparam logic [7:0]  BYTES_FP_UNIMP = 8'h10;
  localparam logic [7:0]  BYTES_ACC_ERR  = 8'h3c;
  localparam logic [15:0] FMTVEC_WORD    = 16'h402c;
  localparam logic [31:0] OFS_PC         = 32'h00000002;
  localparam logic [31:0] OFS_FMTVEC     = 32'h00000006;
  localparam logic [31:0] OFS_EA         = 32'h00000008;
  localparam logic [31:0] OFS_FPC        = 32'h0000000c;
  localparam int          SR_SUPER       = 13;
  localparam int          SR_TRACE_LOW   = 14;
  localparam int          SR_TRACE_HIGH  = 15;
  localparam int          PAGE_BITS      = 12;
  localparam logic [11:0] CRM_ACSR       = 12'h805;
  localparam logic [11:0] CRM_USER_ROOT  = 12'h806;
  localparam logic [11:0] CRM_SUPV_ROOT  = 12'h807;
  localparam logic [15:0] ACSR_RESET     = 16'h0000;
  localparam logic [2:0]  LAST_PUSH_STEP = 3'h4;

  typedef enum logic [7:0] {
    S_IDLE  = 8'h01,
    S_TWAIT = 8'h02,
    S_TPUSH = 8'h04,
    S_TVEC  = 8'h08,
    S_TPREF = 8'h10,
    S_RFMT  = 8'h20,
    S_RSR   = 8'h40,
    S_RPC   = 8'h80
  } efh_state_t;
endpackage : efh_pkg

// [rtl/efh_xfer_seq.sv]
`timescale 1ns/10ps
`default_nettype none
module efh_xfer_seq (
  input  wire logic        mclk,      // Processor clock.
  input  wire logic        rst_n,     // Asynchronous reset, active low.
  input  wire logic        start,     // Begin one item transfer.
  input  wire logic [31:0] addr,      // Even byte address of the item.
  input  wire logic        isLong,    // Item is 32 bits, else 16.
  input  wire logic        isWrite,   // Write item, else read.
  input  wire logic [31:0] wdata,     // Item to write.
  input  wire logic        memAck,    // Memory completes the access.
  input  wire logic [31:0] memRdata,  // Read data, words in low half.
  output logic             memReq,    // Access request, held to ack.
  output logic             memWe,     // Access is a write.
  output logic             memLong,   // Access is a long-word.
  output logic [31:0]      memAddr,   // Access byte address.
  output logic [31:0]      memWdata,  // Write data, words in low half.
  output logic             done,      // Item finished, one cycle.
  output logic [31:0]      rdata      // Assembled read item.
);
  logic        req_q, req_d, we_q, we_d, long_q, long_d, pend_q, pend_d;
  logic        split_q, split_d, done_q, done_d;
  logic [31:0] addr_q, addr_d, wd_q, wd_d, rd_q, rd_d;
  logic [15:0] lo_q, lo_d, hi_q, hi_d;

  ////////////////////////////////////////////////////////////////////////
  // A long item at a long-aligned address moves in one access; any other
  // long item falls back to two word accesses, upper half first.
  always_comb begin
    req_d = req_q; we_d = we_q; long_d = long_q; pend_d = pend_q;
    split_d = split_q; addr_d = addr_q; wd_d = wd_q; rd_d = rd_q;
    lo_d = lo_q; hi_d = hi_q; done_d = 1'b0;
    if (!req_q && start) begin
      req_d   = 1'b1;
      we_d    = isWrite;
      addr_d  = addr;
      long_d  = isLong && !addr[1];                          // [RULE_05]
      split_d = isLong && addr[1];
      pend_d  = isLong && addr[1];
      lo_d    = wdata[15:0];
      wd_d    = (isLong && !addr[1]) ? wdata
              : (isLong ? {16'h0000, wdata[31:16]} : {16'h0000, wdata[15:0]});
    end else if (req_q && memAck) begin
      if (pend_q) begin
        pend_d = 1'b0;
        hi_d   = memRdata[15:0];
        addr_d = addr_q + 32'h00000002;
        wd_d   = {16'h0000, lo_q};
      end else begin
        req_d  = 1'b0;
        done_d = 1'b1;
        rd_d   = long_q ? memRdata
               : (split_q ? {hi_q, memRdata[15:0]} : {16'h0000, memRdata[15:0]});
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      req_q <= 1'b0; we_q <= 1'b0; long_q <= 1'b0; pend_q <= 1'b0;
      split_q <= 1'b0; done_q <= 1'b0; addr_q <= 32'h0; wd_q <= 32'h0;
      rd_q <= 32'h0; lo_q <= 16'h0; hi_q <= 16'h0;
    end else begin
      req_q <= req_d; we_q <= we_d; long_q <= long_d; pend_q <= pend_d;
      split_q <= split_d; done_q <= done_d; addr_q <= addr_d; wd_q <= wd_d;
      rd_q <= rd_d; lo_q <= lo_d; hi_q <= hi_d;
    end
  end

  assign memReq   = req_q;
  assign memWe    = we_q;
  assign memLong  = long_q;
  assign memAddr  = addr_q;
  assign memWdata = wd_q;
  assign done     = done_q;
  assign rdata    = rd_q;
endmodule : efh_xfer_seq
`default_nettype wire

// [verification/efh_mem_model.sv]
`timescale 1ns/10ps
`default_nettype none
module efh_mem_model (
  input  wire logic        mclk,        // Processor clock.
  input  wire logic        rst_n,       // Reset, active low.
  input  wire logic [3:0]  waitCycles,  // Wait cycles before each ack.
  input  wire logic        memReq,      // Access request.
  input  wire logic        memWe,       // Access is a write.
  input  wire logic        memLong,     // Access is a long-word.
  input  wire logic [31:0] memAddr,     // Byte address.
  input  wire logic [31:0] memWdata,    // Write data.
  output logic             memAck,      // Access complete.
  output logic [31:0]      memRdata,    // Read data.
  output int               longCnt      // Long-word accesses seen.
);
  logic [15:0] mem [logic [31:0]];
  logic [3:0]  cnt;

  function automatic logic [15:0] rd(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : 16'h0000;
  endfunction : rd

  // Outside the ack cycle the read bus flips, so a late sample sees junk.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      memAck   <= 1'b0;
      memRdata <= 32'h5a5a5a5a;
      cnt      <= 4'h0;
      longCnt  <= 0;
    end else if (memAck) begin
      memAck   <= 1'b0;
      memRdata <= ~memRdata;
      cnt      <= 4'h0;
      longCnt  <= longCnt + int'(memLong);
      if (memWe && memLong) begin
        mem[memAddr]         = memWdata[31:16];
        mem[memAddr + 32'h2] = memWdata[15:0];
      end else if (memWe) begin
        mem[memAddr] = memWdata[15:0];
      end
    end else if (memReq && cnt >= waitCycles) begin
      memAck   <= 1'b1;
      memRdata <= memLong ? {rd(memAddr), rd(memAddr + 32'h2)} : {16'h0000, rd(memAddr)};
    end else if (memReq) begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : efh_mem_model
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import efh_pkg::*;
  typedef struct packed {
    logic        err;
    logic [15:0] sr;
    logic [31:0] pc;
    logic [31:0] ssp;
  } efh_exp_t;
  logic        mclk, rst_n, fpTrapReq, priorBusy, rteReq, memAck, memReq, memWe, memLong;
  logic        busy, ctxLoad, fmtErr, xlatOpReq, xlatOpDone, cacheOpReq, cacheOpGo;
  logic        crmReq, crmWrite, crmAck;
  logic [3:0]  waitCycles;
  logic [7:0]  fmtErrVector;
  logic [11:0] crmCode;
  logic [15:0] srIn, srOut, crmWdata, crmRdata, v;
  logic [16:0] c;
  logic [31:0] nextPc, faultPc, effAddr, vbr, sspIn, memRdata, memAddr, memWdata, pcOut;
  logic [31:0] sspOut, cacheOpAddr, cacheBlkBase, r, h, b, sp;
  int          errors, num_checks, seqSeen, xlatSeen, longCnt, n0;
  efh_exp_t    ctxQ[$];
  efh_exp_t    e, m;
  logic [31:0] blkQ[$];
  logic [16:0] crmQ[$];

  efh_exception_frame_handler efh_exception_frame_handler_i (
    .mclk(mclk), .rst_n(rst_n), .fpTrapReq(fpTrapReq), .priorBusy(priorBusy),
    .srIn(srIn), .nextPc(nextPc), .faultPc(faultPc), .effAddr(effAddr), .vbr(vbr),
    .sspIn(sspIn), .rteReq(rteReq), .memAck(memAck), .memRdata(memRdata),
    .memReq(memReq), .memWe(memWe), .memLong(memLong), .memAddr(memAddr),
    .memWdata(memWdata), .busy(busy), .ctxLoad(ctxLoad), .srOut(srOut), .pcOut(pcOut),
    .sspOut(sspOut), .fmtErr(fmtErr), .fmtErrVector(fmtErrVector),
    .xlatOpReq(xlatOpReq), .xlatOpDone(xlatOpDone), .cacheOpReq(cacheOpReq),
    .cacheOpAddr(cacheOpAddr), .cacheOpGo(cacheOpGo), .cacheBlkBase(cacheBlkBase),
    .crmReq(crmReq), .crmWrite(crmWrite), .crmCode(crmCode), .crmWdata(crmWdata),
    .crmAck(crmAck), .crmRdata(crmRdata)
  );
  efh_mem_model efh_mem_model_i (
    .mclk(mclk), .rst_n(rst_n), .waitCycles(waitCycles), .memReq(memReq), .memWe(memWe),
    .memLong(memLong), .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck),
    .memRdata(memRdata), .longCnt(longCnt)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic put16(input logic [31:0] a, input logic [15:0] d);
    efh_mem_model_i.mem[a] = d;
  endtask : put16

  function automatic logic [31:0] get32(input logic [31:0] a);
    return {efh_mem_model_i.rd(a), efh_mem_model_i.rd(a + 32'h2)};
  endfunction : get32

  task automatic frame(input logic [31:0] a, input logic [3:0] f, input logic [31:0] d);
    put16(a, d[15:0]);
    put16(a + 32'h2, d[31:16]);
    put16(a + 32'h4, d[15:0]);
    put16(a + 32'h6, {f, 12'h000});
  endtask : frame

  task automatic seq(input logic trap, input logic [31:0] ssp);
    int n;
    n = seqSeen;
    ctxQ.push_back(e);
    @(posedge mclk);
    sspIn     <= ssp;
    fpTrapReq <= trap;
    rteReq    <= !trap;
    priorBusy <= trap;
    @(posedge mclk);
    fpTrapReq <= 1'b0;
    rteReq    <= 1'b0;
    if (trap) repeat (5) begin
      @(posedge mclk);
      chk("memReq while earlier work pends", 32'h0, {31'h0, memReq});
      chk("busy while earlier work pends", 32'h1, {31'h0, busy});
    end
    priorBusy <= 1'b0;
    for (int i = 0; i < 500 && seqSeen == n; i++) @(posedge mclk);
    chk("sequence ended", 32'h1, {31'h0, seqSeen != n});
  endtask : seq

  task automatic results;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    if (rst_n && (ctxLoad || fmtErr)) begin
      if (ctxQ.size() == 0) begin
        chk("unexpected context", 32'h0, 32'h1);
      end else begin
        m = ctxQ.pop_front();
        chk("fmtErr", {31'h0, m.err}, {31'h0, fmtErr});
        if (m.err) chk("fmtErrVector", {24'h0, VEC_FMT_ERR}, {24'h0, fmtErrVector});
        else begin
          chk("srOut", {16'h0, m.sr}, {16'h0, srOut});
          chk("pcOut", m.pc, pcOut);
          chk("sspOut", m.ssp, sspOut);
        end
      end
      chk("busy after sequence", 32'h0, {31'h0, busy});
      seqSeen++;
    end
    if (rst_n && cacheOpGo) chk("cacheBlkBase", blkQ.pop_front(), cacheBlkBase);
    if (rst_n && xlatOpDone) xlatSeen++;
    if (rst_n && crmAck) begin
      c = crmQ.pop_front();
      if (c[16]) chk("crmRdata", {16'h0, c[15:0]}, {16'h0, crmRdata});
    end
  end

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  initial begin
    #(25 * 60000);
    chk("watchdog", 32'h0, 32'h1);
    results();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, fpTrapReq, priorBusy, rteReq, xlatOpReq, cacheOpReq, crmReq, crmWrite} = 8'h00;
    {srIn, crmWdata, crmCode, waitCycles} = 48'h0;
    {nextPc, faultPc, effAddr, vbr, sspIn, cacheOpAddr} = 192'h0;
    void'($urandom(32'hab6577d9));
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      r  = $urandom;
      b  = {12'h001, r[19:8], 8'h00};
      h  = {8'h20, r[23:2], 2'b00};
      sp = i ? 32'h1002 : 32'h1000;
      put16(b + 32'(VEC_FLINE) * 4, h[31:16]);
      put16(b + 32'(VEC_FLINE) * 4 + 32'h2, h[15:0]);
      vbr        <= b;
      srIn       <= {3'b110, r[12:0]};
      nextPc     <= $urandom;
      faultPc    <= $urandom;
      effAddr    <= $urandom;
      waitCycles <= i ? 4'h3 : 4'h0;
      e  = '{1'b0, {3'b001, r[12:0]}, h, sp - 32'h10};
      n0 = longCnt;
      seq(1'b1, sp);
      sp = sp - 32'h10;
      chk("frame status", {19'h0, r[12:0]} | 32'hc000, get32(sp - 32'h2) & 32'hffff);
      chk("frame next pc", nextPc, get32(sp + 32'h2));
      chk("frame format", {16'h0, FMT_FP_UNIMP, 12'(32'(VEC_FLINE) * 4)},
          get32(sp + 32'h4) & 32'hffff);
      chk("frame address", effAddr, get32(sp + 32'h8));
      chk("frame fault pc", faultPc, get32(sp + 32'hc));
      chk("long transfers", i ? 32'h3 : 32'h4, 32'(longCnt - n0));
      $display("trap test %0d done", i);
    end
    // Every format code is tried on return; unsupported codes expect a format error.
    for (int f = 0; f < 16; f++) begin
      r  = $urandom;
      sp = 32'h4000 + 32'(f) * 32'h100 + {30'h0, r[0], 1'b0};
      frame(sp, 4'(f), r);
      if (f == 1) frame(sp + 32'h8, 4'h2, r);
      b = (f == 0) ? 32'd8 : (f == 1) ? 32'd20 : (f == 2 || f == 3) ? 32'd12 : 32'd0;
      b = (f == 4) ? 32'd16 : (f == 7) ? 32'd60 : b;
      e = '{b == 0, r[15:0], {r[31:16], r[15:0]}, sp + b};
      waitCycles <= {2'b00, r[2:1]};
      seq(1'b0, sp);
    end
    $display("return tests done");
    n0 = xlatSeen;
    @(posedge mclk);
    for (int k = 0; k < 7; k++) begin
      r = $urandom;
      if (k == 1) v = r[15:0];
      xlatOpReq   <= k < 3;
      cacheOpReq  <= 1'b1;
      cacheOpAddr <= r;
      blkQ.push_back({r[31:12], 12'h000});
      crmReq      <= 1'b1;
      crmWrite    <= k inside {1, 2, 3};
      crmWdata    <= r[15:0];
      crmCode     <= (k inside {0, 1, 4}) ? CRM_ACSR : (k inside {2, 5}) ? CRM_USER_ROOT : CRM_SUPV_ROOT;
      crmQ.push_back({k inside {0, 4, 5, 6}, k == 4 ? v : ACSR_RESET});
      @(posedge mclk);
    end
    {xlatOpReq, cacheOpReq, crmReq, crmWrite} <= 4'h0;
    repeat (3) @(posedge mclk);
    chk("translation retires", 32'h3, 32'(xlatSeen - n0));
    chk("pending results", 32'h0, 32'(blkQ.size() + crmQ.size()));
    $display("side operation tests done");
    results();
  end
endmodule : tb_top
`default_nettype wire
